// File: inc/ccss_cfg.svh
`ifndef CCSS_CFG_SVH
`define CCSS_CFG_SVH

// register byte offsets on the apb bus
`define CCSS_OFF_OSC_RUN      8'h00
`define CCSS_OFF_SYS_SEL      8'h04
`define CCSS_OFF_SUB_SEL      8'h08

// oscillator_run_control field positions
`define CCSS_ORC_X1_HALT      7
`define CCSS_ORC_FIXED_ONE    6
`define CCSS_ORC_MID_EN       1
`define CCSS_ORC_HIGH_HALT    0

// system_clock_select field positions
`define CCSS_SCS_CPU_STATE    7
`define CCSS_SCS_CPU_CHOICE   6
`define CCSS_SCS_MAIN_STATE   5
`define CCSS_SCS_MAIN_CHOICE  4
`define CCSS_SCS_ONCHIP_STATE 1
`define CCSS_SCS_ONCHIP_CHOICE 0

// subsystem_source_select field positions
`define CCSS_SSS_LOW_PICK     0

// reset values of the writable fields
`define CCSS_RST_X1_HALT      1'b1
`define CCSS_RST_MID_EN       1'b0
`define CCSS_RST_HIGH_HALT    1'b0
`define CCSS_RST_CHOICE       1'b0
`define CCSS_RST_LOW_PICK     1'b0

`endif

// File: inc/ccss_pkg.sv
package ccss_pkg;

  // clock sources; value is the bit index in ccss_osc_t
  typedef enum logic [1:0]
  {
    SRC_HIGH = 2'h0,
    SRC_MID  = 2'h1,
    SRC_X1   = 2'h2,
    SRC_LOW  = 2'h3
  } ccss_src_t;

  // switch sequencer states, gray along idle-drop-take
  typedef enum logic [1:0]
  {
    SEQ_IDLE = 2'h0,
    SEQ_DROP = 2'h1,
    SEQ_TAKE = 2'h3
  } ccss_seq_t;

  // one bit per clock source
  typedef struct packed
  {
    logic low;
    logic x1;
    logic mid;
    logic high;
  } ccss_osc_t;

  // status seen by software after a switch completes
  typedef struct packed
  {
    logic cpu_on_sub;
    logic main_on_x1;
    logic onchip_on_mid;
  } ccss_stat_t;

endpackage

// File: core/ccss_sync.sv
`timescale 1ns/100ps
`default_nettype none

// three-stage synchroniser with agreement filter
module ccss_sync
  import ccss_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
)
(
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic resetn_in,
  // asynchronous level and its clean copy
  input  wire logic async_in,
  output var  logic sync_out
);

  logic stage1_reg;  // metastability catcher
  logic stage2_reg;  // second stage
  logic stage3_reg;  // third stage

  // shift chain; stage1 is read only by stage2
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
      stage3_reg <= RESET_VAL;
    end
    else
    begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // accept a change once stages two and three agree
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      sync_out <= RESET_VAL;
    else if (stage2_reg == stage3_reg)
      sync_out <= stage3_reg;
  end

endmodule
`default_nettype wire

// File: core/ccss_src_pick.sv
`timescale 1ns/100ps
`default_nettype none

// decodes the requested cpu clock source from the choice bits
module ccss_src_pick
  import ccss_pkg::*;
(
  // choice bits from system_clock_select
  input  wire logic cpu_clock_choice_in,
  input  wire logic main_clock_choice_in,
  input  wire logic onchip_osc_choice_in,
  // requested source
  output var  ccss_src_t target_out
);

  // subsystem wins, then external main clock, then on-chip pair
  always_comb
  begin
    if (cpu_clock_choice_in)
      target_out = SRC_LOW;
    else if (main_clock_choice_in)
      target_out = SRC_X1;
    else if (onchip_osc_choice_in)
      target_out = SRC_MID;
    else
      target_out = SRC_HIGH;
  end

endmodule
`default_nettype wire

// File: core/ccss_top.sv
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "ccss_cfg.svh"

module ccss_top
  import ccss_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              resetn_in,
  // apb slave
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  input  wire logic [3:0]        pstrb_in,
  output var  logic [31:0]       prdata_out,
  output var  logic              pready_out,
  output var  logic              pslverr_out,
  // oscillator run controls and their running indications
  output var  ccss_osc_t         osc_run_out,
  input  wire ccss_osc_t         osc_live_in,
  // clock gate enables and gate acknowledges
  output var  ccss_osc_t         gate_en_out,
  input  wire ccss_osc_t         gate_ack_in,
  // source currently driving the cpu clock
  output var  ccss_src_t         cpu_src_out
);

  // writable control fields
  logic       x1_osc_halt_reg;        // x1 oscillator halted
  logic       mid_osc_enable_reg;     // middle oscillator on
  logic       high_osc_halt_reg;      // high oscillator halted
  logic       cpu_clock_choice_reg;   // cpu from subsystem
  logic       main_clock_choice_reg;  // main from x1
  logic       onchip_osc_choice_reg;  // on-chip from middle
  logic       low_osc_pick_reg;       // low oscillator on
  // switch state
  ccss_stat_t stat_reg;               // status after switch
  ccss_seq_t  seq_reg;                // sequencer state
  ccss_src_t  pend_reg;               // source being switched to
  logic [3:0] gate_reg;               // gate enables
  // decode and bus helpers
  ccss_src_t  target_src;             // requested source
  logic [3:0] live_sync;              // synced oscillator live
  logic [3:0] ack_sync;               // synced gate acknowledge
  logic [7:0] rd_byte;                // selected register image
  logic       addr_hit;               // address maps a register
  logic       setup_phase;            // apb setup cycle
  logic       wr_take;                // write completes now
  logic       wr_lane;                // low byte lane written

  // apb phase decode
  assign setup_phase = psel_in & ~penable_in;
  assign wr_take     = psel_in & penable_in & pready_out & pwrite_in;
  assign wr_lane     = pstrb_in[0];

  // address decode and read image
  always_comb
  begin
    rd_byte  = 8'h00;
    addr_hit = 1'b1;
    // oscillator_run_control image
    if (paddr_in == ADDR_W'(`CCSS_OFF_OSC_RUN))
    begin
      rd_byte[`CCSS_ORC_X1_HALT]   = x1_osc_halt_reg;
      rd_byte[`CCSS_ORC_FIXED_ONE] = 1'b1;
      rd_byte[`CCSS_ORC_MID_EN]    = mid_osc_enable_reg;
      rd_byte[`CCSS_ORC_HIGH_HALT] = high_osc_halt_reg;
    end
    // system_clock_select image with live status
    else if (paddr_in == ADDR_W'(`CCSS_OFF_SYS_SEL))
    begin
      rd_byte[`CCSS_SCS_CPU_STATE]     = stat_reg.cpu_on_sub;
      rd_byte[`CCSS_SCS_CPU_CHOICE]    = cpu_clock_choice_reg;
      rd_byte[`CCSS_SCS_MAIN_STATE]    = stat_reg.main_on_x1;
      rd_byte[`CCSS_SCS_MAIN_CHOICE]   = main_clock_choice_reg;
      rd_byte[`CCSS_SCS_ONCHIP_STATE]  = stat_reg.onchip_on_mid;
      rd_byte[`CCSS_SCS_ONCHIP_CHOICE] = onchip_osc_choice_reg;
    end
    // subsystem_source_select image
    else if (paddr_in == ADDR_W'(`CCSS_OFF_SUB_SEL))
    begin
      rd_byte[`CCSS_SSS_LOW_PICK] = low_osc_pick_reg;
    end
    // unmapped address
    else
    begin
      addr_hit = 1'b0;
    end
  end

  // zero-wait answer: ready and data registered in the setup cycle
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end
    else
    begin
      pready_out  <= setup_phase;
      pslverr_out <= setup_phase & ~addr_hit;
      // read data only for a mapped read
      if (setup_phase & ~pwrite_in & addr_hit)
        prdata_out <= {24'h00_0000, rd_byte};
      else
        prdata_out <= 32'h0000_0000;
    end
  end

  // oscillator_run_control writes
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      x1_osc_halt_reg    <= `CCSS_RST_X1_HALT;
      mid_osc_enable_reg <= `CCSS_RST_MID_EN;
      high_osc_halt_reg  <= `CCSS_RST_HIGH_HALT;
    end
    else if (wr_take && wr_lane &&
             paddr_in == ADDR_W'(`CCSS_OFF_OSC_RUN))
    begin
      x1_osc_halt_reg    <= pwdata_in[`CCSS_ORC_X1_HALT];
      mid_osc_enable_reg <= pwdata_in[`CCSS_ORC_MID_EN];
      high_osc_halt_reg  <= pwdata_in[`CCSS_ORC_HIGH_HALT];
    end
  end

  // system_clock_select writes; status bits are read only
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cpu_clock_choice_reg  <= `CCSS_RST_CHOICE;
      main_clock_choice_reg <= `CCSS_RST_CHOICE;
      onchip_osc_choice_reg <= `CCSS_RST_CHOICE;
    end
    else if (wr_take && wr_lane &&
             paddr_in == ADDR_W'(`CCSS_OFF_SYS_SEL))
    begin
      cpu_clock_choice_reg  <= pwdata_in[`CCSS_SCS_CPU_CHOICE];
      main_clock_choice_reg <= pwdata_in[`CCSS_SCS_MAIN_CHOICE];
      onchip_osc_choice_reg <= pwdata_in[`CCSS_SCS_ONCHIP_CHOICE];
    end
  end

  // subsystem_source_select writes
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      low_osc_pick_reg <= `CCSS_RST_LOW_PICK;
    else if (wr_take && wr_lane &&
             paddr_in == ADDR_W'(`CCSS_OFF_SUB_SEL))
      low_osc_pick_reg <= pwdata_in[`CCSS_SSS_LOW_PICK];
  end

  // oscillator run outputs follow the control fields
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      osc_run_out.x1   <= ~`CCSS_RST_X1_HALT;
      osc_run_out.mid  <= `CCSS_RST_MID_EN;
      osc_run_out.high <= ~`CCSS_RST_HIGH_HALT;
      osc_run_out.low  <= `CCSS_RST_LOW_PICK;
    end
    else
    begin
      osc_run_out.x1   <= ~x1_osc_halt_reg;
      osc_run_out.mid  <= mid_osc_enable_reg;
      osc_run_out.high <= ~high_osc_halt_reg;
      osc_run_out.low  <= low_osc_pick_reg;
    end
  end

  // requested source from the choice bits
  ccss_src_pick u_pick
  (
    .cpu_clock_choice_in  (cpu_clock_choice_reg),
    .main_clock_choice_in (main_clock_choice_reg),
    .onchip_osc_choice_in (onchip_osc_choice_reg),
    .target_out           (target_src)
  );

  // synchronise live and acknowledge levels from the clock domains
  for (genvar i = 0; i < 4; i++)
  begin : g_sync
    ccss_sync #(.RESET_VAL(i == 0)) u_live
    (
      .sys_clk_in (sys_clk_in),
      .resetn_in  (resetn_in),
      .async_in   (osc_live_in[i]),
      .sync_out   (live_sync[i])
    );
    ccss_sync #(.RESET_VAL(i == 0)) u_ack
    (
      .sys_clk_in (sys_clk_in),
      .resetn_in  (resetn_in),
      .async_in   (gate_ack_in[i]),
      .sync_out   (ack_sync[i])
    );
  end

  // switch sequencer: drop old gate, wait for it, raise new gate
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      seq_reg  <= SEQ_IDLE;
      pend_reg <= SRC_HIGH;
      gate_reg <= 4'h1;
    end
    else
    begin
      case (seq_reg)
        // wait for a new request whose oscillator is live
        SEQ_IDLE:
        begin
          // switch only to a running source
          if (target_src != cpu_src_out && live_sync[target_src])
          begin
            gate_reg <= 4'h0;
            pend_reg <= target_src;
            seq_reg  <= SEQ_DROP;
          end
        end
        // old gate closed at a low phase of its clock
        SEQ_DROP:
        begin
          if (!ack_sync[cpu_src_out])
          begin
            gate_reg[pend_reg] <= 1'b1;
            seq_reg            <= SEQ_TAKE;
          end
        end
        // new gate opened, waiting for its acknowledge
        SEQ_TAKE:
        begin
          if (ack_sync[pend_reg])
            seq_reg <= SEQ_IDLE;
        end
        // unused code returns to idle
        default:
        begin
          seq_reg <= SEQ_IDLE;
        end
      endcase
    end
  end

  // active source and status change only after the new gate acks
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cpu_src_out <= SRC_HIGH;
      stat_reg    <= '0;
    end
    else if (seq_reg == SEQ_TAKE && ack_sync[pend_reg])
    begin
      cpu_src_out <= pend_reg;
      stat_reg.cpu_on_sub <= (pend_reg == SRC_LOW);
      if (pend_reg != SRC_LOW)
        stat_reg.main_on_x1 <= (pend_reg == SRC_X1);
      if (pend_reg == SRC_HIGH || pend_reg == SRC_MID)
        stat_reg.onchip_on_mid <= (pend_reg == SRC_MID);
    end
  end

  // gate enable outputs registered again from the sequencer flops, one cycle behind gate_reg
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      gate_en_out <= ccss_osc_t'(4'h1);
    else
      gate_en_out <= ccss_osc_t'(gate_reg);
  end

endmodule
`default_nettype wire

// File: testbench/ccss_top_chk.sv
`timescale 1ns/100ps
`default_nettype none
// watches gate ordering, run enables and status coherence
module ccss_chk
  import ccss_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock, reset and apb
  input wire logic              sys_clk_in,
  input wire logic              resetn_in,
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0]       pwdata_in,
  input wire logic [3:0]        pstrb_in,
  input wire logic [31:0]       prdata_out,
  input wire logic              pready_out,
  input wire logic              pslverr_out,
  // oscillators, gates and source
  input wire ccss_osc_t         osc_run_out,
  input wire ccss_osc_t         osc_live_in,
  input wire ccss_osc_t         gate_en_out,
  input wire ccss_osc_t         gate_ack_in,
  input wire ccss_src_t         cpu_src_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  // completed write and status read
  logic       wr_ok;
  logic       rd_ok;
  logic [3:0] en_v;
  logic [3:0] ack_v;
  assign wr_ok = psel_in && penable_in && pready_out && pwrite_in
                 && pstrb_in[0];
  assign rd_ok = psel_in && penable_in && pready_out && !pwrite_in
                 && paddr_in == ADDR_W'(8'h04);
  assign en_v  = gate_en_out;
  assign ack_v = gate_ack_in;

  a_gate_onehot: assert property ($onehot0(gate_en_out))
    else $error("two clock gates open");
  a_break_first: assert property (
    gate_en_out != 4'h0 && $changed(gate_en_out)
    |-> $past(gate_en_out) == 4'h0) else $error("gate made before break");
  a_status_acked: assert property ($changed(cpu_src_out)
    |-> en_v[cpu_src_out] && ack_v[cpu_src_out])
    else $error("source moved before gate ack");
  a_mid_start: assert property (
    wr_ok && paddr_in == ADDR_W'(8'h00)
    |-> ##2 osc_run_out.mid == $past(pwdata_in[1], 2))
    else $error("mid run enable wrong");
  a_high_halt: assert property (
    wr_ok && paddr_in == ADDR_W'(8'h00)
    |-> ##2 osc_run_out.high == !$past(pwdata_in[0], 2))
    else $error("high run enable wrong");
  a_x1_start: assert property (
    wr_ok && paddr_in == ADDR_W'(8'h00)
    |-> ##2 osc_run_out.x1 == !$past(pwdata_in[7], 2))
    else $error("x1 run enable wrong");
  a_low_start: assert property (
    wr_ok && paddr_in == ADDR_W'(8'h08)
    |-> ##2 osc_run_out.low == $past(pwdata_in[0], 2))
    else $error("low run enable wrong");
  a_cpu_state: assert property (
    rd_ok |-> prdata_out[7] == ($past(cpu_src_out) == SRC_LOW))
    else $error("cpu state bit wrong");
  a_onchip_state: assert property (
    rd_ok && $past(cpu_src_out) == SRC_MID |-> prdata_out[1])
    else $error("onchip state bit low");
  a_main_state: assert property (
    rd_ok && $past(cpu_src_out) == SRC_X1 |-> prdata_out[5])
    else $error("main state bit low");
endmodule

bind ccss_top ccss_chk #(.ADDR_W(ADDR_W)) u_ccss_chk
(
  .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .osc_run_out(osc_run_out), .osc_live_in(osc_live_in),
  .gate_en_out(gate_en_out), .gate_ack_in(gate_ack_in),
  .cpu_src_out(cpu_src_out)
);
`default_nettype wire

// File: testbench/test_cpu_clock_source_switch.sv
`timescale 1ns/100ps
`default_nettype none
// walks the cpu clock through middle, low, x1 and back to high
module test_cpu_clock_source_switch
  import ccss_pkg::*;
;
  // design ports
  logic        sys_clk_in = 1'b0;
  logic        resetn_in, psel_in, penable_in, pwrite_in;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in;
  logic [3:0]  pstrb_in;
  logic [31:0] prdata_out;
  logic        pready_out, pslverr_out;
  ccss_osc_t   osc_run_out, osc_live_in, gate_en_out, gate_ack_in;
  ccss_src_t   cpu_src_out;
  // bookkeeping and last read
  localparam int MID_SETTLE = 500;    // 4 us of 8 ns cycles
  localparam int LOW_SETTLE = 26250;  // 210 us of 8 ns cycles
  int          bad_count, compares;
  logic [31:0] q;
  logic        err;

  always #4 sys_clk_in = ~sys_clk_in;

  // oscillators run and gates pass one cycle after being enabled
  always @(posedge sys_clk_in)
  begin
    osc_live_in <= osc_run_out;
    gate_ack_in <= gate_en_out;
  end

  ccss_top #(.ADDR_W(8)) u_ccss_top
  (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .osc_run_out(osc_run_out), .osc_live_in(osc_live_in),
    .gate_en_out(gate_en_out), .gate_ack_in(gate_ack_in),
    .cpu_src_out(cpu_src_out)
  );

  // compares one value and counts it
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; reads right after an edge see what it sampled
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= wr;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    // hold the access until pready is seen at a rising edge
    do
      @(posedge sys_clk_in);
    while (pready_out !== 1'b1);
    q = prdata_out;
    err = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    // run outputs follow a write one edge later; let them settle
    repeat (2) @(posedge sys_clk_in);
  endtask

  // idles a number of clock edges with the bus released
  task automatic idle(input int cycles);
    repeat (cycles) @(posedge sys_clk_in);
  endtask

  // rereads a register until one bit shows the wanted level
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, a, 32'h0);
      n++;
    end
    while (q[b] !== v && n < 40);
  endtask

  // reset values and an unmapped place
  task automatic t_reset();
    chk("run_rst", {28'h0, osc_run_out}, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk("osc_ctl_rst", q, 32'hc0);
    apb(1'b0, 8'h04, 32'h0);
    chk("sys_sel_rst", q, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk("sub_sel_rst", q, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped_err", {31'h0, err}, 32'h1);
  endtask

  // high to middle, then halt high
  task automatic t_mid();
    apb(1'b1, 8'h00, 32'h82);
    chk("run_mid", {28'h0, osc_run_out}, 32'h3);
    idle(MID_SETTLE);
    apb(1'b1, 8'h04, 32'h01);
    poll(8'h04, 1, 1'b1);
    chk("sys_sel_mid", q, 32'h03);
    chk("src_mid", {30'h0, cpu_src_out}, 32'h1);
    chk("gate_mid", {28'h0, gate_en_out}, 32'h2);
    apb(1'b1, 8'h00, 32'h83);
    chk("run_nohigh", {28'h0, osc_run_out}, 32'h2);
  endtask

  // middle to low through the subsystem path
  task automatic t_low();
    apb(1'b1, 8'h08, 32'h01);
    chk("run_low", {28'h0, osc_run_out}, 32'ha);
    idle(LOW_SETTLE);
    apb(1'b1, 8'h04, 32'h41);
    poll(8'h04, 7, 1'b1);
    chk("sys_sel_low", q, 32'hc3);
    chk("src_low", {30'h0, cpu_src_out}, 32'h3);
    chk("gate_low", {28'h0, gate_en_out}, 32'h8);
  endtask

  // low to x1, restarting high on the way
  task automatic t_x1();
    apb(1'b1, 8'h00, 32'h02);
    chk("run_all", {28'h0, osc_run_out}, 32'hf);
    apb(1'b1, 8'h04, 32'h10);
    poll(8'h04, 5, 1'b1);
    chk("sys_sel_x1", {28'h0, q[7:4]}, 32'h3);
    chk("src_x1", {30'h0, cpu_src_out}, 32'h2);
    chk("gate_x1", {28'h0, gate_en_out}, 32'h4);
  endtask

  // x1 back to high
  task automatic t_high();
    apb(1'b1, 8'h04, 32'h00);
    poll(8'h04, 5, 1'b0);
    chk("sys_sel_high", q, 32'h0);
    chk("src_high", {30'h0, cpu_src_out}, 32'h0);
    chk("gate_high", {28'h0, gate_en_out}, 32'h1);
  endtask

  // prints the counts and the verdict
  task automatic summarize();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // main sequence
  initial
  begin
    bad_count = 0;
    compares = 0;
    resetn_in = 1'b0;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 8'h00;
    pwdata_in = 32'h0;
    pstrb_in = 4'h1;
    osc_live_in = 4'h1;
    gate_ack_in = 4'h1;
    repeat (10) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    @(posedge sys_clk_in);
    t_reset();
    t_mid();
    t_low();
    t_x1();
    t_high();
    // reset again in mid-run and recheck the defaults
    resetn_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    @(posedge sys_clk_in);
    t_reset();
    summarize();
  end

  // cuts a hang short; the settle waits alone take about 27k cycles
  initial
  begin
    #400000;
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire
